// ==== core/xcvr_ctrl.sv ====
`timescale 1ns/1ps
`include "xcvr_consts.svh"

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `FIFO_DEPTH_DEF
) (
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_size_check
        $error("byte_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [CW-1:0]    count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign count     = count_ff;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_ff <= '0;
        end else if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr_ff <= '0;
        end else if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
        end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
        end
    end

    AST_FIFO_BOUND: assert property (@(posedge sys_clk) disable iff (!nrst)
        count_ff <= CW'(DEPTH) and (push && !pop |=> count_ff == $past(count_ff) + 1'b1))
        else $error("fifo count out of range or missed push");

endmodule

module xcvr_ctrl #(
    parameter int DEPTH = `FIFO_DEPTH_DEF
) (
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    input  wire xcvr_pkg::host_req_t        host_req,
    output logic [7:0]                      rd_data_ff,
    output logic                            tx_fifo_ready,
    input  wire logic                       dtr_n,
    input  wire logic                       transmit_slot_ready,
    output logic                            line_tx_en_ff,
    output logic                            line_rx_en_ff,
    output logic                            tx_byte_valid,
    input  wire logic                       tx_byte_ready,
    output logic [7:0]                      tx_byte,
    input  wire logic                       rx_byte_valid,
    output logic                            rx_byte_ready,
    input  wire logic [7:0]                 rx_byte,
    input  wire logic [$clog2(DEPTH+1)-1:0] rx_trigger,
    output logic                            rx_irq_ff,
    output logic                            tx_irq_ff,
    input  wire xcvr_pkg::frame_cfg_t       frame_cfg,
    output xcvr_pkg::frame_cfg_t            frame_cfg_ff
);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2) begin : g_depth_check
        $error("xcvr_ctrl: DEPTH must be at least 2");
    end

    logic [7:0]                    mode_sel_ff;
    logic [7:0]                    nxt_mode_sel;
    logic [`MODE_FIELD_W-1:0]      nxt_mode;
    logic                          mode_wr;
    logic                          data_wr;
    logic                          data_rd;
    logic                          rx_out_valid;
    logic [7:0]                    rx_head;
    logic [CW-1:0]                 rx_count;
    logic [CW-1:0]                 tx_count;
    logic                          nxt_tx_en;
    logic                          nxt_rx_en;
    logic                          wrote_ff;

    assign mode_wr = host_req.wr && (host_req.addr == `OFS_MODE_SELECT);
    assign data_wr = host_req.wr && (host_req.addr == `OFS_DATA);
    assign data_rd = host_req.rd && (host_req.addr == `OFS_DATA);

    assign nxt_mode_sel = mode_wr ? host_req.wdata : mode_sel_ff;
    assign nxt_mode     = nxt_mode_sel[`MODE_FIELD_W-1:0];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_sel_ff <= `MODE_SEL_RESET;
        end else begin
            mode_sel_ff <= nxt_mode_sel;
        end
    end

    // Gating is computed from the incoming mode so it acts on the write edge
    always_comb begin
        nxt_tx_en = 1'b1;
        nxt_rx_en = 1'b1;
        case (nxt_mode)
            `MODE_FOUR_WIRE: begin
                nxt_tx_en = 1'b1;
                nxt_rx_en = 1'b1;
            end
            `MODE_ECHO: begin
                nxt_tx_en = dtr_n;
                nxt_rx_en = 1'b1;
            end
            `MODE_DTR_CTRL: begin
                nxt_tx_en = dtr_n;
                nxt_rx_en = !dtr_n;
            end
            default: begin
                nxt_tx_en = transmit_slot_ready;
                nxt_rx_en = !transmit_slot_ready;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            line_tx_en_ff <= 1'b1;
            line_rx_en_ff <= 1'b1;
        end else begin
            line_tx_en_ff <= nxt_tx_en;
            line_rx_en_ff <= nxt_rx_en;
        end
    end

    // Transmit path: host writes, serializer drains
    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (data_wr),
        .in_ready  (tx_fifo_ready),
        .in_data   (host_req.wdata),
        .out_valid (tx_byte_valid),
        .out_ready (tx_byte_ready),
        .out_data  (tx_byte),
        .count     (tx_count)
    );

    // Receive path: serializer fills, host reads at data offset
    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (rx_byte_valid),
        .in_ready  (rx_byte_ready),
        .in_data   (rx_byte),
        .out_valid (rx_out_valid),
        .out_ready (data_rd),
        .out_data  (rx_head),
        .count     (rx_count)
    );

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_ff <= `READ_UNMAPPED;
        end else if (host_req.rd) begin
            if (host_req.addr == `OFS_MODE_SELECT) begin
                rd_data_ff <= mode_sel_ff;
            end else if (host_req.addr == `OFS_DATA && rx_out_valid) begin
                rd_data_ff <= rx_head;
            end else begin
                rd_data_ff <= `READ_UNMAPPED;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_irq_ff <= 1'b0;
        end else begin
            rx_irq_ff <= (rx_trigger != '0) && (rx_count >= rx_trigger);
        end
    end

    // Refill request while the transmit FIFO is empty
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_irq_ff <= 1'b0;
        end else begin
            tx_irq_ff <= (tx_count == '0);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_cfg_ff <= '0;
        end else begin
            frame_cfg_ff <= frame_cfg;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrote_ff <= 1'b0;
        end else if (mode_wr) begin
            wrote_ff <= 1'b1;
        end
    end

    sequence s_mode_write;
        mode_wr ##1 1'b1;
    endsequence

    AST_FOUR_WIRE: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_sel_ff[1:0] == `MODE_FOUR_WIRE |-> line_tx_en_ff && line_rx_en_ff)
        else $error("four-wire mode did not enable both ends");

    AST_DEFAULT_MODE: assert property (@(posedge sys_clk) disable iff (!nrst)
        !wrote_ff |-> mode_sel_ff == `MODE_SEL_RESET && line_tx_en_ff)
        else $error("mode not four-wire before first write");

    AST_ECHO: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_sel_ff[1:0] == `MODE_ECHO |-> line_tx_en_ff == $past(dtr_n) && line_rx_en_ff)
        else $error("echo gating wrong");

    AST_DTR_CTRL: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_sel_ff[1:0] == `MODE_DTR_CTRL |-> line_rx_en_ff == !$past(dtr_n) && line_tx_en_ff != line_rx_en_ff)
        else $error("dtr controlled gating wrong");

    AST_AUTO: assert property (@(posedge sys_clk) disable iff (!nrst)
        mode_sel_ff[1:0] == `MODE_AUTO |-> line_tx_en_ff == $past(transmit_slot_ready)
        && line_rx_en_ff == !$past(transmit_slot_ready))
        else $error("auto gating wrong");

    AST_MODE_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_mode_write |-> mode_sel_ff == $past(host_req.wdata)
        && (mode_sel_ff[1:0] != `MODE_FOUR_WIRE || line_tx_en_ff))
        else $error("mode write not applied at once");

    AST_UPPER_BITS: assert property (@(posedge sys_clk) disable iff (!nrst)
        host_req.rd && host_req.addr == `OFS_MODE_SELECT |=> rd_data_ff == $past(mode_sel_ff))
        else $error("scratch readback wrong");

    AST_RX_TRIGGER: assert property (@(posedge sys_clk) disable iff (!nrst)
        rx_trigger != '0 && rx_count >= rx_trigger |=> rx_irq_ff)
        else $error("receive trigger missed");

    AST_SPLIT_FIFOS: assert property (@(posedge sys_clk) disable iff (!nrst)
        data_wr && tx_fifo_ready && !tx_byte_valid |=> tx_byte_valid && tx_byte == $past(host_req.wdata))
        else $error("transmit FIFO lost a byte");

endmodule

// ==== core/xcvr_consts.svh ====
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

`define OFS_DATA        3'h0
`define OFS_MODE_SELECT 3'h7
`define MODE_FIELD_W    2
`define MODE_FOUR_WIRE  2'h0
`define MODE_ECHO       2'h1
`define MODE_DTR_CTRL   2'h2
`define MODE_AUTO       2'h3
`define MODE_SEL_RESET  8'h00
`define READ_UNMAPPED   8'h00
`define FIFO_DEPTH_DEF  4

`endif

// ==== core/xcvr_pkg.sv ====
package xcvr_pkg;

    typedef enum logic [1:0] {
        PARITY_NONE,
        PARITY_EVEN,
        PARITY_ODD
    } parity_t;

    // Frame settings handed to the serializer
    typedef struct packed {
        parity_t     parity;
        logic [1:0]  data_bits_sel;
        logic        stop_two;
        logic [15:0] baud_div;
    } frame_cfg_t;

    // One host access on the port register window
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_t;

endpackage

// ==== testbench/xcvr_partner.sv ====
`timescale 1ns/1ps
module xcvr_partner (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       stall,
    input  wire logic       tx_byte_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       line_tx_en_ff,
    input  wire logic       line_rx_en_ff,
    output logic            tx_byte_ready,
    output logic            rx_byte_valid,
    input  wire logic       rx_byte_ready,
    output logic [7:0]      rx_byte
);
    logic [7:0] echo_q[$];
    // Serializer; a byte on the shared pair returns while the receiver listens
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_byte_ready <= 1'b0;
            rx_byte_valid <= 1'b0;
            rx_byte <= 8'h00;
            echo_q.delete();
        end else begin
            tx_byte_ready <= !stall;
            if (tx_byte_valid && tx_byte_ready && line_tx_en_ff && line_rx_en_ff) begin
                echo_q.push_back(tx_byte);
            end
            if (rx_byte_valid && rx_byte_ready) begin
                rx_byte_valid <= 1'b0;
                rx_byte <= ~rx_byte;
            end else if (!rx_byte_valid && echo_q.size() > 0) begin
                rx_byte_valid <= 1'b1;
                rx_byte <= echo_q.pop_front();
            end else if (!rx_byte_valid) begin
                rx_byte <= ~rx_byte;
            end
        end
    end
endmodule

// ==== testbench/xcvr_ctrl_bench.sv ====
`timescale 1ns/1ps
module xcvr_ctrl_bench;
    logic                 sys_clk = 1'b0;
    logic                 nrst = 1'b0;
    xcvr_pkg::host_req_t  host_req = '0;
    logic [7:0]           rd_data_ff;
    logic                 tx_fifo_ready;
    logic                 dtr_n = 1'b1;
    logic                 slot = 1'b0;
    logic                 line_tx_en_ff;
    logic                 line_rx_en_ff;
    logic                 tx_byte_valid;
    logic                 tx_byte_ready;
    logic [7:0]           tx_byte;
    logic                 rx_byte_valid;
    logic                 rx_byte_ready;
    logic [7:0]           rx_byte;
    logic [2:0]           rx_trigger = 3'h0;
    logic                 rx_irq_ff;
    logic                 tx_irq_ff;
    logic                 stall = 1'b0;
    xcvr_pkg::frame_cfg_t frame_cfg = '0;
    xcvr_pkg::frame_cfg_t frame_cfg_ff;
    int                   bad_count = 0;
    int                   tests_run = 0;

    always #25 sys_clk = ~sys_clk;

    xcvr_ctrl #(.DEPTH(4)) DUT (.sys_clk(sys_clk), .nrst(nrst), .host_req(host_req),
        .rd_data_ff(rd_data_ff), .tx_fifo_ready(tx_fifo_ready), .dtr_n(dtr_n),
        .transmit_slot_ready(slot), .line_tx_en_ff(line_tx_en_ff), .line_rx_en_ff(line_rx_en_ff),
        .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte),
        .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready), .rx_byte(rx_byte),
        .rx_trigger(rx_trigger), .rx_irq_ff(rx_irq_ff), .tx_irq_ff(tx_irq_ff),
        .frame_cfg(frame_cfg), .frame_cfg_ff(frame_cfg_ff));

    xcvr_partner far_end (.sys_clk(sys_clk), .nrst(nrst), .stall(stall), .tx_byte_valid(tx_byte_valid),
        .tx_byte(tx_byte), .line_tx_en_ff(line_tx_en_ff), .line_rx_en_ff(line_rx_en_ff),
        .tx_byte_ready(tx_byte_ready), .rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
        .rx_byte(rx_byte));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // One host access; read data is settled on return
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_req <= {wr, !wr, a, d};
        @(posedge sys_clk);
        host_req <= '0;
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        test_done();
    end

    initial begin
        int m;
        int v;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        bus(1'b0, 3'h7, 8'h00);
        chk(rd_data_ff, 8'h00);
        chk({line_tx_en_ff, line_rx_en_ff}, 2'h3);
        bus(1'b0, 3'h3, 8'h00);
        chk(rd_data_ff, 8'h00);
        for (m = 0; m < 4; m++) begin
            bus(1'b1, 3'h7, 8'hfc | m[7:0]);
            bus(1'b0, 3'h7, 8'h00);
            chk(rd_data_ff, 8'hfc | m[7:0]);
            for (v = 0; v < 4; v++) begin
                @(posedge sys_clk);
                dtr_n <= v[0];
                slot <= v[1];
                repeat (2) @(posedge sys_clk);
                #1;
                chk({line_tx_en_ff, line_rx_en_ff}, {m == 0 || (m == 3 ? v[1] : v[0]),
                    m < 2 || (m == 2 ? !v[0] : !v[1])});
            end
        end
        @(posedge sys_clk);
        dtr_n <= 1'b1;
        stall <= 1'b1;
        rx_trigger <= 3'h2;
        bus(1'b1, 3'h7, 8'h01);
        // One refill block no larger than the transmit FIFO
        for (v = 0; v < 4; v++) bus(1'b1, 3'h0, 8'(8'h11 * (v + 1)));
        chk({tx_fifo_ready, tx_irq_ff, tx_byte_valid}, 3'h1);
        @(posedge sys_clk);
        stall <= 1'b0;
        // Drain takes four cycles, the echo two cycles per byte
        repeat (16) @(posedge sys_clk);
        #1;
        chk({rx_irq_ff, rx_byte_ready, tx_irq_ff}, 3'h5);
        for (v = 0; v < 5; v++) begin
            bus(1'b0, 3'h0, 8'h00);
            chk(rd_data_ff, v < 4 ? 8'(8'h11 * (v + 1)) : 8'h00);
        end
        chk(rx_irq_ff, 1'b0);
        bus(1'b1, 3'h7, 8'h02);
        bus(1'b1, 3'h0, 8'h77);
        repeat (6) @(posedge sys_clk);
        chk({tx_irq_ff, tx_byte_valid}, 2'h2);
        bus(1'b0, 3'h0, 8'h00);
        chk(rd_data_ff, 8'h00);
        for (v = 0; v < 3; v++) begin
            @(posedge sys_clk);
            frame_cfg <= {xcvr_pkg::parity_t'(v), 2'(v), v[0], 16'h0a5c ^ 16'(v)};
            repeat (2) @(posedge sys_clk);
            #1;
            chk(24'(frame_cfg_ff), 24'(frame_cfg));
        end
        // Reset in mid-run falls back to four-wire from DTR-controlled
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        bus(1'b0, 3'h7, 8'h00);
        chk({rd_data_ff, line_tx_en_ff, line_rx_en_ff}, 10'h003);
        test_done();
    end
endmodule
